// File: swc_pkg.sv
// Purpose: Constants for the sleep and wake-up controller.
// Assumes: APB register access, 200 MHz pclk.
// Notes: Function list below.
// Function
// - Executing the sleep instruction enters power-down.
// - Entry clears watchdog, clears power-down flag, sets expiry flag, stops oscillator.
// - I/O pins keep their pre-sleep drive state during power-down.
// - Watchdog reset is internal and never drives the reset pin.
// - Wake on reset pin, enabled watchdog expiry, or enabled interrupt.
// - Reset pin wake resets fully; watchdog and interrupt wake continue.
// - Power-down flag set at power-up, cleared by each sleep.
// - Expiry flag clears when watchdog expiry caused the wake.
// - During sleep the next instruction at PC plus one is prefetched.
// - Interrupt wakes only if individually enabled, whatever the global enable.
// - After interrupt wake, run prefetched instruction, then vector if global enable.
// - Global disable with an enabled pending flag makes sleep a no-op.
// - Watchdog clears on every wake from power-down.
// - Crystal modes wait 1024 oscillator periods; resistor-capacitor mode about 1 us.
// - Interrupt flags set on their event regardless of enables.
// - Watchdog expiry during power-down wakes instead of resetting.
`default_nettype none
package swc_pkg;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_FLAG = 8'h08;
  localparam logic [7:0] OFF_ENABLE = 8'h0C;
  localparam int NSRC = 3;
  localparam int SRC_EDGE = 0;
  localparam int SRC_PORT = 1;
  localparam int SRC_PERIPH = 2;
  localparam int CTRL_WDT_EN = 0;
  localparam int CTRL_IRQ_EN = 1;
  localparam int CTRL_MODE_LO = 2;
  localparam int CTRL_EDGE_RISE = 4;
  localparam logic [4:0] CTRL_RESET = 5'h11;
  localparam int CLK_PERIOD_NS = 5;
  localparam int TOST_PERIODS = 1024;
  localparam int RC_DELAY_NS = 1000;
  localparam int RC_CYC = (RC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] VECTOR_ADDR = 16'h0004;
  typedef enum logic [1:0] {
    MODE_LOWPWR = 2'b00,
    MODE_STDXTAL = 2'b01,
    MODE_FASTXTAL = 2'b10,
    MODE_RC = 2'b11
  } swc_osc_mode_t;
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_SLEEP = 3'b010,
    ST_WAKE = 3'b100
  } swc_state_t;
endpackage : swc_pkg
`default_nettype wire

// File: swc_sleep_ctrl.sv
// Purpose: Power-down entry and wake-up sequencing with APB registers.
// Assumes: Core gives a one-cycle sleep_exec pulse; watchdog on pclk.
// Notes: Reset pin and edge pin are asynchronous and filtered here.
`default_nettype none
module swc_sleep_ctrl #(
  parameter int PC_W = 13,
  parameter int OSC_PERIOD_NS = 250,
  parameter int XTAL_WAIT_CYC = (swc_pkg::TOST_PERIODS * OSC_PERIOD_NS
                                 + swc_pkg::CLK_PERIOD_NS - 1) / swc_pkg::CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Processor core
  input wire logic sleep_exec,
  input wire logic [PC_W-1:0] pc_in,
  output logic sleep_nop,
  output logic [PC_W-1:0] prefetch_addr,
  output logic core_halt,
  output logic resume,
  output logic vector_take,
  output logic [15:0] vector_addr,
  // Watchdog
  input wire logic wdt_expire,
  output logic wdt_clear,
  output logic wdt_enable,
  // Pins and interrupt sources
  input wire logic ext_reset_pin_n,
  input wire logic edge_irq_pin,
  input wire logic port_change_irq,
  input wire logic periph_irq,
  // System outputs
  output logic osc_drive_en,
  output logic io_hold,
  output logic sys_reset,
  output logic irq
);
  localparam int RC_CYC = swc_pkg::RC_CYC;

  swc_pkg::swc_state_t state_r, state_nxt;
  logic [4:0] ctrl_r;
  logic [swc_pkg::NSRC-1:0] flag_r, en_r, set_v, clr_v;
  logic power_down_flag, expiry_flag;
  logic [31:0] cnt_r;
  logic by_irq_r;
  logic [2:0] rst_s, edg_s;
  logic rst_lvl_n, edg_lvl, edg_prev;
  logic access, wr, wake_irq, ext_rst_act, wdt_hit, sleep_go;
  logic sleep_nop_r, resume_r, vector_r, wdt_clear_r, sys_reset_r;
  logic osc_en_r, io_hold_r;
  logic [31:0] prdata_r;
  logic [PC_W-1:0] prefetch_r;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == swc_pkg::OFF_CTRL) || (a == swc_pkg::OFF_STATUS) ||
             (a == swc_pkg::OFF_FLAG) || (a == swc_pkg::OFF_ENABLE);
  endfunction : mapped

  // Pin filters: a change counts once the second and third stages agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_s <= 3'b111;
      edg_s <= 3'b000;
      rst_lvl_n <= 1'b1;
      edg_lvl <= 1'b0;
      edg_prev <= 1'b0;
    end else begin
      rst_s <= {rst_s[1:0], ext_reset_pin_n};
      edg_s <= {edg_s[1:0], edge_irq_pin};
      if (rst_s[1] == rst_s[2]) begin
        rst_lvl_n <= rst_s[2];
      end
      if (edg_s[1] == edg_s[2]) begin
        edg_lvl <= edg_s[2];
      end
      edg_prev <= edg_lvl;
    end
  end

  assign access = psel && penable;
  assign wr = access && pwrite;
  assign ext_rst_act = !rst_lvl_n;
  assign wdt_enable = ctrl_r[swc_pkg::CTRL_WDT_EN];
  assign wdt_hit = wdt_expire && wdt_enable;
  assign wake_irq = |(flag_r & en_r);
  assign sleep_go = sleep_exec && !(!ctrl_r[swc_pkg::CTRL_IRQ_EN] && wake_irq);

  // Flag events; a set in the same cycle as a write-one clear wins.
  always_comb begin
    set_v = '0;
    set_v[swc_pkg::SRC_EDGE] = ctrl_r[swc_pkg::CTRL_EDGE_RISE] ?
                               (edg_lvl && !edg_prev) : (!edg_lvl && edg_prev);
    set_v[swc_pkg::SRC_PORT] = port_change_irq;
    set_v[swc_pkg::SRC_PERIPH] = periph_irq;
    clr_v = '0;
    if (wr && paddr == swc_pkg::OFF_FLAG) begin
      clr_v = pwdata[swc_pkg::NSRC-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= '0;
    end else begin
      flag_r <= (flag_r & ~clr_v) | set_v;
    end
  end

  // Control and enable registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= swc_pkg::CTRL_RESET;
      en_r <= '0;
    end else begin
      if (wr && paddr == swc_pkg::OFF_CTRL) begin
        ctrl_r <= pwdata[4:0];
      end
      if (wr && paddr == swc_pkg::OFF_ENABLE) begin
        en_r <= pwdata[swc_pkg::NSRC-1:0];
      end
    end
  end

  // State sequencing.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      swc_pkg::ST_RUN: begin
        if (!ext_rst_act && !wdt_hit && sleep_go) begin
          state_nxt = swc_pkg::ST_SLEEP;
        end
      end
      swc_pkg::ST_SLEEP: begin
        if (ext_rst_act || wdt_hit || wake_irq) begin
          state_nxt = swc_pkg::ST_WAKE;
        end
      end
      swc_pkg::ST_WAKE: begin
        if (cnt_r == 32'h0000_0000) begin
          state_nxt = swc_pkg::ST_RUN;
        end
      end
      default: state_nxt = swc_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= swc_pkg::ST_RUN;
      osc_en_r <= 1'b1;
      io_hold_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      osc_en_r <= (state_nxt != swc_pkg::ST_SLEEP);
      io_hold_r <= (state_nxt == swc_pkg::ST_SLEEP);
    end
  end

  // Start-up delay counter, loaded on the wake event.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      by_irq_r <= 1'b0;
    end else if (state_r == swc_pkg::ST_SLEEP && state_nxt == swc_pkg::ST_WAKE) begin
      cnt_r <= (ctrl_r[3:2] == swc_pkg::MODE_RC) ? 32'(RC_CYC - 1)
                                                  : 32'(XTAL_WAIT_CYC - 1);
      by_irq_r <= !ext_rst_act && !wdt_hit;
    end else if (state_r == swc_pkg::ST_WAKE && cnt_r != 32'h0000_0000) begin
      cnt_r <= cnt_r - 32'h0000_0001;
    end
  end

  // Status flags: power-down set at power-up, expiry set at power-up.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_down_flag <= 1'b1;
      expiry_flag <= 1'b1;
    end else begin
      if (state_r == swc_pkg::ST_RUN && state_nxt == swc_pkg::ST_SLEEP) begin
        power_down_flag <= 1'b0;
        expiry_flag <= 1'b1;
      end
      if (wdt_hit && !ext_rst_act) begin
        expiry_flag <= 1'b0;
      end
    end
  end

  // Core and watchdog strobes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_nop_r <= 1'b0;
      resume_r <= 1'b0;
      vector_r <= 1'b0;
      wdt_clear_r <= 1'b0;
      sys_reset_r <= 1'b0;
      prefetch_r <= '0;
    end else begin
      sleep_nop_r <= (state_r == swc_pkg::ST_RUN) && sleep_exec && !sleep_go;
      resume_r <= (state_r == swc_pkg::ST_WAKE) && (state_nxt == swc_pkg::ST_RUN);
      vector_r <= (state_r == swc_pkg::ST_WAKE) && (state_nxt == swc_pkg::ST_RUN) &&
                  by_irq_r && ctrl_r[swc_pkg::CTRL_IRQ_EN];
      wdt_clear_r <= (state_r != state_nxt) && (state_r != swc_pkg::ST_WAKE);
      // Watchdog reset only while running; the pin is never driven.
      sys_reset_r <= ext_rst_act || (wdt_hit && state_r == swc_pkg::ST_RUN);
      if (state_r == swc_pkg::ST_RUN && sleep_exec) begin
        prefetch_r <= pc_in + PC_W'(1);
      end
    end
  end

  // APB read data is captured in the setup cycle, so there are no wait states.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (psel && !penable) begin
      case (paddr)
        swc_pkg::OFF_CTRL: prdata_r <= {27'h000_0000, ctrl_r};
        swc_pkg::OFF_STATUS: prdata_r <= {27'h000_0000, state_r, expiry_flag, power_down_flag};
        swc_pkg::OFF_FLAG: prdata_r <= {29'h0000_0000, flag_r};
        swc_pkg::OFF_ENABLE: prdata_r <= {29'h0000_0000, en_r};
        default: prdata_r <= '0;
      endcase
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = access && !mapped(paddr);
  assign sleep_nop = sleep_nop_r;
  assign prefetch_addr = prefetch_r;
  assign core_halt = (state_r != swc_pkg::ST_RUN);
  assign resume = resume_r;
  assign vector_take = vector_r;
  assign vector_addr = swc_pkg::VECTOR_ADDR;
  assign wdt_clear = wdt_clear_r;
  assign osc_drive_en = osc_en_r;
  assign io_hold = io_hold_r;
  assign sys_reset = sys_reset_r;
  assign irq = wake_irq;

  // Sequencing checks; each one names the rule that it guards.
  a_sleep_entry: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == swc_pkg::ST_RUN && sleep_go && !ext_rst_act && !wdt_hit) |=>
    (state_r == swc_pkg::ST_SLEEP && !power_down_flag && expiry_flag && wdt_clear &&
     !osc_drive_en))
    else $error("sleep entry effects missing");

  a_sleep_nop: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == swc_pkg::ST_RUN && sleep_exec && !ctrl_r[swc_pkg::CTRL_IRQ_EN] && wake_irq)
    |=> (state_r == swc_pkg::ST_RUN && sleep_nop))
    else $error("sleep not turned into no-op");

  a_io_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == swc_pkg::ST_SLEEP) |-> (io_hold && !osc_drive_en && core_halt))
    else $error("pins not held in power-down");

  a_wdt_wake: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == swc_pkg::ST_SLEEP && wdt_hit && !ext_rst_act) |=>
    (state_r == swc_pkg::ST_WAKE && !expiry_flag && !sys_reset && wdt_clear))
    else $error("watchdog wake wrong");

  a_wdt_reset: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == swc_pkg::ST_RUN && wdt_hit) |=> (sys_reset && !expiry_flag))
    else $error("watchdog reset missing");

  a_irq_wake: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == swc_pkg::ST_SLEEP && wake_irq && !wdt_hit && !ext_rst_act) |=>
    (state_r == swc_pkg::ST_WAKE && by_irq_r))
    else $error("interrupt wake missing");

  a_rc_delay: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == swc_pkg::ST_SLEEP && wake_irq && ctrl_r[3:2] == swc_pkg::MODE_RC)
    |=> (cnt_r == 32'(RC_CYC - 1)) ##1 (core_halt && cnt_r == 32'(RC_CYC - 2)))
    else $error("start-up delay load wrong");

  a_halt_end: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == swc_pkg::ST_WAKE && cnt_r == 32'h0000_0000) |=> (resume && !core_halt))
    else $error("resume not after delay");

  a_vector: assert property (@(posedge pclk) disable iff (!presetn)
    vector_take |-> (resume && $past(ctrl_r[swc_pkg::CTRL_IRQ_EN]) && vector_addr == 16'h0004))
    else $error("vector without resume");

  a_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    port_change_irq |=> flag_r[swc_pkg::SRC_PORT])
    else $error("flag not set by event");

  a_prefetch: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == swc_pkg::ST_RUN && sleep_exec) |=>
    (prefetch_addr == $past(pc_in) + PC_W'(1)))
    else $error("prefetch address wrong");
endmodule : swc_sleep_ctrl
`default_nettype wire

// File: swc_core_model.sv
// Purpose: Core and watchdog model facing the sleep controller.
// Assumes: Watchdog runs on pclk; the bench asks for each sleep instruction.
// Notes: A halted core issues nothing, so sleep requests in sleep are dropped.
`default_nettype none
module swc_core_model #(
  parameter int PC_W = 13,
  parameter int WDT_PERIOD = 150
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench requests
  input wire logic sleep_req,
  input wire logic [PC_W-1:0] pc_req,
  // Core side
  input wire logic core_halt,
  output logic sleep_exec,
  output logic [PC_W-1:0] pc_in,
  // Watchdog side
  input wire logic wdt_clear,
  input wire logic wdt_enable,
  output logic wdt_expire
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] wdt_cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_exec <= 1'b0;
      pc_in <= '0;
    end else begin
      sleep_exec <= sleep_req & ~core_halt;
      pc_in <= pc_req;
    end
  end
  // The count keeps running in sleep and restarts on every clear pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_cnt_r <= 16'h0000;
      wdt_expire <= 1'b0;
    end else if (wdt_clear || !wdt_enable) begin
      wdt_cnt_r <= 16'h0000;
      wdt_expire <= 1'b0;
    end else if (wdt_cnt_r == 16'(WDT_PERIOD - 1)) begin
      wdt_cnt_r <= 16'h0000;
      wdt_expire <= 1'b1;
    end else begin
      wdt_cnt_r <= wdt_cnt_r + 16'h0001;
      wdt_expire <= 1'b0;
    end
  end
endmodule : swc_core_model
`default_nettype wire

// File: sleep_wakeup_control_tb.sv
// Purpose: Self-checking bench for the sleep and wake-up controller.
// Assumes: APB master tasks, core and watchdog model, 200 MHz pclk.
// Notes: Crystal start-up is shortened through XTAL_WAIT_CYC.
`default_nettype none
module sleep_wakeup_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PC_W = 13;
  localparam int XT_CYC = 20;
  localparam int WDT_P = 150;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic sleep_exec, sleep_nop, core_halt, resume, vector_take, wdt_expire, wdt_clear;
  logic wdt_enable, ext_reset_pin_n, edge_irq_pin, port_change_irq, periph_irq;
  logic osc_drive_en, io_hold, sys_reset, irq, sleep_req;
  logic [PC_W-1:0] pc_in, prefetch_addr, pc_req;
  logic [15:0] vector_addr;
  int bad_count, tests_run, n, mark, rst_cnt, nop_cnt;
  swc_sleep_ctrl #(.PC_W(PC_W), .XTAL_WAIT_CYC(XT_CYC)) i_swc_sleep_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_exec(sleep_exec), .pc_in(pc_in), .sleep_nop(sleep_nop),
    .prefetch_addr(prefetch_addr), .core_halt(core_halt), .resume(resume),
    .vector_take(vector_take), .vector_addr(vector_addr), .wdt_expire(wdt_expire),
    .wdt_clear(wdt_clear), .wdt_enable(wdt_enable), .ext_reset_pin_n(ext_reset_pin_n),
    .edge_irq_pin(edge_irq_pin), .port_change_irq(port_change_irq), .periph_irq(periph_irq),
    .osc_drive_en(osc_drive_en), .io_hold(io_hold), .sys_reset(sys_reset), .irq(irq));
  swc_core_model #(.PC_W(PC_W), .WDT_PERIOD(WDT_P)) i_swc_core_model (
    .pclk(pclk), .presetn(presetn), .sleep_req(sleep_req), .pc_req(pc_req),
    .core_halt(core_halt), .sleep_exec(sleep_exec), .pc_in(pc_in), .wdt_clear(wdt_clear),
    .wdt_enable(wdt_enable), .wdt_expire(wdt_expire));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (sys_reset === 1'b1) rst_cnt <= rst_cnt + 1;
    if (sleep_nop === 1'b1) nop_cnt <= nop_cnt + 1;
  end
  task final_report;
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task limit(input int k, input int lim);
    if (k >= lim) begin
      bad_count++;
      $display("[ERR] t=%0t wait=%h limit=%h", $time, k, lim);
      final_report();
    end
  endtask : limit
  // One APB transfer; read data and error are taken at the edge that sees pready.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    limit(k, 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic sig(input int s);
    case (s)
      0: return resume;
      1: return wdt_expire;
      2: return sys_reset;
      default: return ~core_halt;
    endcase
  endfunction : sig
  task wait_on(input int s);
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (sig(s) !== 1'b1 && n < 2000);
    limit(n, 2000);
  endtask : wait_on
  task do_sleep(input logic [PC_W-1:0] pc);
    @(posedge pclk);
    sleep_req <= 1'b1;
    pc_req <= pc;
    @(posedge pclk);
    sleep_req <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
  endtask : do_sleep
  function automatic logic [31:0] sts(input logic pd, input logic ex,
                                      input swc_pkg::swc_state_t s);
    return {27'h000_0000, s, ex, pd};
  endfunction : sts
  initial begin
    {presetn, psel, penable, pwrite, sleep_req} = 5'h00;
    {edge_irq_pin, port_change_irq, periph_irq} = 3'h0;
    ext_reset_pin_n = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pc_req = '0;
    bad_count = 0;
    tests_run = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, swc_pkg::OFF_STATUS, 32'h0000_0000);
    chk(rd, sts(1'b1, 1'b1, swc_pkg::ST_RUN));
    apb(1'b0, swc_pkg::OFF_CTRL, 32'h0000_0000);
    chk(rd, 32'(swc_pkg::CTRL_RESET));
    apb(1'b1, swc_pkg::OFF_STATUS, 32'h0000_0000);
    apb(1'b0, swc_pkg::OFF_STATUS, 32'h0000_0000);
    chk(rd, sts(1'b1, 1'b1, swc_pkg::ST_RUN));
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk({err, rd[30:0]}, 32'h8000_0000);
    chk(32'(vector_addr), 32'h0000_0004);
    apb(1'b1, swc_pkg::OFF_CTRL, 32'h0000_001C);
    apb(1'b1, swc_pkg::OFF_ENABLE, 32'h0000_0002);
    do_sleep(13'h0100);
    chk(32'({core_halt, osc_drive_en, io_hold}), 32'h0000_0005);
    chk(32'(prefetch_addr), 32'h0000_0101);
    apb(1'b0, swc_pkg::OFF_STATUS, 32'h0000_0000);
    chk(rd, sts(1'b0, 1'b1, swc_pkg::ST_SLEEP));
    @(posedge pclk);
    port_change_irq <= 1'b1;
    @(posedge pclk);
    port_change_irq <= 1'b0;
    #1;
    chk(32'(irq), 32'h0000_0001);
    wait_on(0);
    chk(n, swc_pkg::RC_CYC + 1);
    chk(32'({vector_take, osc_drive_en, io_hold}), 32'h0000_0002);
    apb(1'b0, swc_pkg::OFF_FLAG, 32'h0000_0000);
    chk(rd, 32'h0000_0002);
    mark = nop_cnt;
    do_sleep(13'h0200);
    chk(32'(nop_cnt - mark), 32'h0000_0001);
    chk(32'(core_halt), 32'h0000_0000);
    apb(1'b1, swc_pkg::OFF_FLAG, 32'h0000_0002);
    apb(1'b0, swc_pkg::OFF_FLAG, 32'h0000_0000);
    chk({irq, rd[30:0]}, 32'h0000_0000);
    apb(1'b1, swc_pkg::OFF_CTRL, 32'h0000_001E);
    apb(1'b1, swc_pkg::OFF_ENABLE, 32'h0000_0000);
    do_sleep(13'h0300);
    @(posedge pclk);
    periph_irq <= 1'b1;
    edge_irq_pin <= 1'b1;
    repeat (3) @(posedge pclk);
    periph_irq <= 1'b0;
    repeat (10) @(posedge pclk);
    apb(1'b0, swc_pkg::OFF_FLAG, 32'h0000_0000);
    chk(rd, 32'h0000_0005);
    chk(32'({irq, core_halt}), 32'h0000_0001);
    apb(1'b1, swc_pkg::OFF_ENABLE, 32'h0000_0004);
    wait_on(0);
    chk(n, swc_pkg::RC_CYC + 1);
    chk(32'(vector_take), 32'h0000_0001);
    apb(1'b1, swc_pkg::OFF_FLAG, 32'h0000_0007);
    edge_irq_pin <= 1'b0;
    apb(1'b1, swc_pkg::OFF_CTRL, 32'h0000_0015);
    mark = rst_cnt;
    do_sleep(13'h0400);
    wait_on(1);
    wait_on(0);
    chk(n, XT_CYC + 1);
    chk(32'(rst_cnt - mark), 32'h0000_0000);
    apb(1'b0, swc_pkg::OFF_STATUS, 32'h0000_0000);
    chk(rd, sts(1'b0, 1'b0, swc_pkg::ST_RUN));
    apb(1'b1, swc_pkg::OFF_CTRL, 32'h0000_001C);
    do_sleep(13'h0500);
    mark = rst_cnt;
    @(posedge pclk);
    ext_reset_pin_n <= 1'b0;
    repeat (10) @(posedge pclk);
    ext_reset_pin_n <= 1'b1;
    chk(32'(rst_cnt > mark), 32'h0000_0001);
    wait_on(3);
    apb(1'b0, swc_pkg::OFF_STATUS, 32'h0000_0000);
    chk(rd, sts(1'b0, 1'b1, swc_pkg::ST_RUN));
    apb(1'b1, swc_pkg::OFF_CTRL, 32'h0000_001D);
    wait_on(2);
    chk(n, WDT_P + 1);
    chk(32'(core_halt), 32'h0000_0000);
    apb(1'b0, swc_pkg::OFF_STATUS, 32'h0000_0000);
    chk(rd, sts(1'b0, 1'b0, swc_pkg::ST_RUN));
    apb(1'b1, swc_pkg::OFF_CTRL, 32'h0000_000C);
    edge_irq_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(1'b0, swc_pkg::OFF_FLAG, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    edge_irq_pin <= 1'b0;
    repeat (8) @(posedge pclk);
    apb(1'b0, swc_pkg::OFF_FLAG, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    final_report();
  end
endmodule : sleep_wakeup_control_tb
`default_nettype wire
